// ==== hdl/bsce_consts.vh ====
// Constants for the bit-test-skip and complement execution block.
// Assumes a 12-bit instruction word and 8-bit file registers.
`ifndef BSCE_CONSTS_VH
`define BSCE_CONSTS_VH
`define BSCE_OPC_BTSC_MSB    11
`define BSCE_OPC_BTSC_LSB    8
`define BSCE_OPC_BTSC        4'h6
`define BSCE_OPC_COMPLEMENT_FILE_OP_MSB    11
`define BSCE_OPC_COMPLEMENT_FILE_OP_LSB    6
`define BSCE_OPC_COMPLEMENT_FILE_OP        6'h09
`define BSCE_BIT_MSB         7
`define BSCE_BIT_LSB         5
`define BSCE_DEST_BIT        5
`define BSCE_ADDR_MSB        4
`define BSCE_ADDR_LSB        0
`define BSCE_ADDR_RST        5'h00
`define BSCE_BYTE_ZERO       8'h00
`define BSCE_BYTE_RST        8'h00
`define BSCE_DEST_W          1'b0
`define BSCE_BYTE_W          8
`define BSCE_ONE_HOT         8'h01
`endif

// ==== hdl/bsce_exec.v ====
// Execution logic for the bit-test-skip-if-clear and complement instructions.
// Assumes the core presents one instruction word per valid cycle and returns
// the addressed file register on file_rdata combinationally in that cycle.
`timescale 1ns/1ps
`include "bsce_consts.vh"

module bsce_exec (
	// Clock and reset
	input  wire        mclk,
	input  wire        sys_rst,
	// Instruction in
	input  wire        instr_valid,
	input  wire [11:0] instr_word,
	// File register read
	output reg  [4:0]  file_addr_q,
	input  wire [7:0]  file_rdata,
	// Results
	output reg         file_we_q,
	output reg  [4:0]  file_waddr_q,
	output reg  [7:0]  file_wdata_q,
	output reg         acc_we_q,
	output reg  [7:0]  acc_wdata_q,
	output reg         zero_we_q,
	output reg         zero_flag_q,
	// Fetch control
	output reg         discard_q,
	output reg         nop_exec_q
);

	// ****************************************************************
	// Skip sequencer states
	// ****************************************************************
	// A skipping test parks the sequencer in ST_KILL for one cycle; the
	// word seen there is the prefetch and is never decoded.
	localparam [0:0] ST_RUN  = 1'b0;
	localparam [0:0] ST_KILL = 1'b1;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	wire       slot_live;
	wire       is_btsc;
	wire       is_complement_file_op;
	wire [2:0] bit_sel;
	wire [4:0] faddr;
	wire       dest_f;
	wire       skip_now;
	wire [7:0] bit_onehot;
	wire [7:0] bit_hit;
	wire [7:0] comp;
	wire       tested;
	reg        state_q;
	reg        state_d;
	reg        discard_d;
	reg        nop_exec_d;
	reg  [4:0] file_addr_d;
	reg        file_we_d;
	reg  [4:0] file_waddr_d;
	reg  [7:0] file_wdata_d;
	reg        acc_we_d;
	reg  [7:0] acc_wdata_d;
	reg        zero_we_d;
	reg        zero_flag_d;
	genvar     gi;

	// ****************************************************************
	// Decode
	// ****************************************************************
	// The read address is taken from the live word so the operand is
	// available in the execute cycle; file_addr_q follows for tracing.
	assign slot_live = instr_valid && (state_q == ST_RUN);
	assign is_btsc   = slot_live &&
		(instr_word[`BSCE_OPC_BTSC_MSB:`BSCE_OPC_BTSC_LSB] == `BSCE_OPC_BTSC);
	assign is_complement_file_op   = slot_live &&
		(instr_word[`BSCE_OPC_COMPLEMENT_FILE_OP_MSB:`BSCE_OPC_COMPLEMENT_FILE_OP_LSB] == `BSCE_OPC_COMPLEMENT_FILE_OP);
	assign bit_sel   = instr_word[`BSCE_BIT_MSB:`BSCE_BIT_LSB];
	assign faddr     = instr_word[`BSCE_ADDR_MSB:`BSCE_ADDR_LSB];
	assign dest_f    = instr_word[`BSCE_DEST_BIT];
	assign skip_now  = is_btsc && !tested;

	// ****************************************************************
	// Operand datapath
	// ****************************************************************
	// One slice per data bit: the complement for the write-back and a
	// one-hot gate that picks the tested bit without a wide mux.
	assign bit_onehot = `BSCE_ONE_HOT << bit_sel;

	generate
		for (gi = 0; gi < `BSCE_BYTE_W; gi = gi + 1) begin : g_bit
			assign comp[gi]    = ~file_rdata[gi];
			assign bit_hit[gi] = file_rdata[gi] & bit_onehot[gi];
		end
	endgenerate

	assign tested = |bit_hit;

	// ****************************************************************
	// Skip sequencer
	// ****************************************************************
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				if (skip_now) begin
					state_d = ST_KILL;
				end
			end
			ST_KILL: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	// ****************************************************************
	// Fetch control
	// ****************************************************************
	// The no-operation is only reported when a word was really there to
	// be killed; an empty slot after the test costs nothing extra.
	always @* begin
		discard_d  = 1'b0;
		nop_exec_d = 1'b0;
		if (skip_now) begin
			discard_d = 1'b1;
		end
		if ((state_q == ST_KILL) && instr_valid) begin
			nop_exec_d = 1'b1;
		end
	end

	// ****************************************************************
	// Result write-back
	// ****************************************************************
	always @* begin
		file_addr_d  = faddr;
		file_we_d    = 1'b0;
		file_waddr_d = file_waddr_q;
		file_wdata_d = file_wdata_q;
		acc_we_d     = 1'b0;
		acc_wdata_d  = acc_wdata_q;
		if (is_complement_file_op) begin
			if (dest_f == `BSCE_DEST_W) begin
				acc_we_d    = 1'b1;
				acc_wdata_d = comp;
			end else begin
				file_we_d    = 1'b1;
				file_waddr_d = faddr;
				file_wdata_d = comp;
			end
		end
	end

	// ****************************************************************
	// Zero flag
	// ****************************************************************
	// The bit test never reaches this path, so the status flag stays as
	// it was across a test, skipping or not.
	always @* begin
		zero_we_d   = 1'b0;
		zero_flag_d = zero_flag_q;
		if (is_complement_file_op) begin
			zero_we_d   = 1'b1;
			zero_flag_d = (comp == `BSCE_BYTE_ZERO);
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Every output leaves from one of these flops, so the core's write
	// ports never see decode glitches from the live instruction word.
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			discard_q  <= 1'b0;
			nop_exec_q <= 1'b0;
		end else begin
			discard_q  <= discard_d;
			nop_exec_q <= nop_exec_d;
		end
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			file_addr_q  <= `BSCE_ADDR_RST;
			file_we_q    <= 1'b0;
			file_waddr_q <= `BSCE_ADDR_RST;
			file_wdata_q <= `BSCE_BYTE_RST;
		end else begin
			file_addr_q  <= file_addr_d;
			file_we_q    <= file_we_d;
			file_waddr_q <= file_waddr_d;
			file_wdata_q <= file_wdata_d;
		end
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_we_q    <= 1'b0;
			acc_wdata_q <= `BSCE_BYTE_RST;
		end else begin
			acc_we_q    <= acc_we_d;
			acc_wdata_q <= acc_wdata_d;
		end
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			zero_we_q   <= 1'b0;
			zero_flag_q <= 1'b0;
		end else begin
			zero_we_q   <= zero_we_d;
			zero_flag_q <= zero_flag_d;
		end
	end

endmodule // bsce_exec

// ==== bench/bsce_properties.sv ====
// Port checks for bsce_exec, bound to it.
`timescale 1ns/1ps
module bsce_chk(input logic mclk,sys_rst,instr_valid,file_we_q,acc_we_q,zero_we_q,zero_flag_q,discard_q,
	nop_exec_q,input logic[11:0]instr_word,input logic[7:0]file_rdata,file_wdata_q,acc_wdata_q,
	input logic[4:0]file_waddr_q);
	wire g=instr_valid&!discard_q,t=g&instr_word[11:8]==4'h6,c=g&instr_word[11:6]==6'h09;
	wire s=t&!file_rdata[instr_word[7:5]];
	default clocking@(posedge mclk);endclocking
	default disable iff(sys_rst);
	chk_skip_kill:assert property(s|=>discard_q)else $error("skip");
	chk_bit_set:assert property(t&!s|=>!discard_q)else $error("set");
	chk_nop_slot:assert property(discard_q&instr_valid|=>nop_exec_q)else $error("nop");
	chk_test_quiet:assert property(t|=>!(zero_we_q|file_we_q|acc_we_q))else $error("flag");
	chk_comp_dest:assert property(c|=>file_we_q==$past(instr_word[5])&acc_we_q!=file_we_q)else $error("dest");
	chk_comp_val:assert property(c|=>~$past(file_rdata)==(file_we_q?file_wdata_q:acc_wdata_q))else $error("val");
	chk_zero_set:assert property(c|=>zero_we_q&zero_flag_q== &$past(file_rdata))else $error("zero");
	chk_comp_addr:assert property(c&instr_word[5]|=>file_waddr_q==$past(instr_word[4:0]))else $error("addr");
	chk_skip_once:assert property(discard_q|=>!discard_q)else $error("once");
	chk_killed_quiet:assert property(discard_q|=>!(zero_we_q|file_we_q|acc_we_q))else $error("kill");
	chk_nop_cause:assert property(!discard_q|=>!nop_exec_q)else $error("cause");
	cover property(s);
	cover property(c&instr_word[5]);
	cover property(discard_q&instr_valid);
	cover property(t&!s);
endmodule // bsce_chk
bind bsce_exec bsce_chk u_chk(.*);

// ==== bench/test_bsce_exec.sv ====
// Random bench for bsce_exec.
`timescale 1ns/1ps
module test_bsce_exec;
	reg mclk=0,sys_rst=1,v=0,p=0,q=0,c=0,d=0;reg[11:0]w=0;reg[7:0]f=0;wire[7:0]fd,ad;wire fw,aw,zw,zf,dq,nq;
	reg ez=0;reg[4:0]ew=0,en=0;reg[7:0]ea=0,ef=0;wire[4:0]fa,wa;
	int seed=32'h19ea8593,err_total=0,checks_done=0,k=0,r;
	bsce_exec dut(.mclk,.sys_rst,.instr_valid(v),.instr_word(w),.file_rdata(f),.file_we_q(fw),.acc_we_q(aw),
	.zero_we_q(zw),.zero_flag_q(zf),.discard_q(dq),.nop_exec_q(nq),.file_wdata_q(fd),.acc_wdata_q(ad),
	.file_addr_q(fa),.file_waddr_q(wa));
	task chk(input[7:0]s,e,input[31:0]m);checks_done++;if(s!==e)begin err_total++;
	$display("ERROR %s exp %h got %h",m,e,s);end endtask
	task end_of_test;$display("%0d checks %0d errors",checks_done,err_total);
	if(err_total==0&&checks_done>0)$display("DONE - PASS");else $display("DONE - FAIL");$finish;endtask
	function sk(input[11:0]i,input[7:0]y);sk=i[11:8]==4'h6&!y[i[7:5]];endfunction
	function [7:0]cp(input[7:0]y);cp=~y;endfunction
	task drv(input a,input[11:0]b,input[7:0]y);@(posedge mclk);v<=a;w<=b;f<=y;endtask
	always #5 mclk=~mclk;
	always@(posedge mclk)if(sys_rst){p,q,c,ea,ef,ew,en,ez}<=0;else begin p<=v&!p&sk(w,f);q<=v&p;
	c<=v&!p&w[11:6]==6'h09;d<=w[5];en<=w[4:0];if(v&!p&w[11:6]==6'h09)begin ez<=cp(f)==0;
	if(w[5])begin ef<=cp(f);ew<=w[4:0];end else ea<=cp(f);end
	if(++k>5000)begin err_total++;end_of_test;end end
	always@(negedge mclk)if(!sys_rst)begin chk(dq,p,"disc");
	chk({nq,fw,aw,zw},{q,c&d,c&!d,c},"strb");
	chk(fa,en,"fadr");
	chk(wa,ew,"wadr");
	chk(fd,ef,"fdat");
	chk(ad,ea,"adat");
	chk(zf,ez,"zflg");end
	initial begin repeat(12)@(posedge mclk);sys_rst<=0;
	drv(1,12'h643,8'hfb);drv(1,12'h264,8'hff);drv(1,12'h264,8'hff);drv(1,12'h643,8'h04);
	drv(1,12'h600,8'hfe);drv(0,12'h000,8'h00);drv(1,12'h244,8'h00);
	repeat(3000)@(posedge mclk)begin r=$random(seed);
	v<=r[15]|r[16];w<=r[13]?{4'h6,r[7:0]}:r[12]?{6'h09,r[5:0]}:r[11:0];f<=r[14]?{8{r[17]}}:r[31:24];end
	end_of_test;end
endmodule // test_bsce_exec
